// ---- common/tjil_pkg.sv ----
// Purpose: shared constants and types of the T1/J1 set-up and LOS block
// Assumes: 8-bit register port, one core clock
// Notes:   offsets are byte addresses on the register port
package tjil_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] A_GLOBAL_CFG  = 8'h00;
   localparam logic [7:0] A_PRIMARY     = 8'h01;
   localparam logic [7:0] A_RX_CTRL     = 8'h02;
   localparam logic [7:0] A_LINE_CODE   = 8'h03;
   localparam logic [7:0] A_LOS_DETECT  = 8'h04;
   localparam logic [7:0] A_LOS_RECOVER = 8'h05;
   localparam logic [7:0] A_LINE_IF2    = 8'h06;
   localparam logic [7:0] A_STATUS      = 8'h07;
   localparam logic [7:0] A_LOS_EVENTS  = 8'h08;
   localparam logic [7:0] A_COMMAND     = 8'h09;
   localparam logic [7:0] A_DECREMENT   = 8'h0a;
   localparam logic [7:0] A_TX_FIFO     = 8'h0b;
   localparam logic [4:0] A_CLK_MODE_HI = 5'h02;
   localparam logic [3:0] A_TX_SIG_HI   = 4'h2;
   localparam logic [3:0] TX_SIG_COUNT  = 4'hc;

   // ==========================================================
   // field positions
   localparam int B_CMD_RX_RESET = 0;
   localparam int B_CMD_TX_RESET = 1;
   localparam int B_CODE_LO      = 0;
   localparam int B_DUAL_RAIL    = 2;
   localparam int B_PRECODE      = 3;

   // ==========================================================
   // reset values and counts
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [2:0] CH_LAST_BIT   = 3'h7;
   localparam logic [3:0] PD_ZERO_RUN   = 4'hf;
   localparam logic [8:0] ONES_SAT      = 9'h1ff;

   // ==========================================================
   // line codes and symbols
   typedef enum logic [1:0] {
      CODE_NRZ     = 2'h0,
      CODE_AMI     = 2'h1,
      CODE_AMI_ZCS = 2'h2,
      CODE_B8ZS    = 2'h3
   } tjil_code_t;

   typedef enum logic [1:0] {
      SYM_ZERO = 2'h0,
      SYM_MARK = 2'h1,
      SYM_V    = 2'h2,
      SYM_B    = 2'h3
   } tjil_sym_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tjil_bus_t;

   typedef struct packed {
      logic stb;
      logic pos;
      logic neg;
   } tjil_rx_t;

   // ==========================================================
   // module state
   typedef struct packed {
      logic        los;
      logic [12:0] zrun;
      logic [12:0] win;
      logic [8:0]  ones;
      logic [3:0]  zr15;
      logic        z15;
      logic        rise;
      logic        fall;
   } tjil_los_st_t;

   typedef struct packed {
      tjil_sym_t [7:0] slot;
      logic [2:0]      cnt;
      logic            pol;
      logic            lp;
      logic            ln;
   } tjil_cod_st_t;

   typedef struct packed {
      logic             extra_recovery_irq_en;
      logic             primary_mode_select;
      logic             j1;
      tjil_code_t       code;
      logic             dual;
      logic             precode;
      logic [7:0]       los_detect_count;
      logic [7:0]       los_recovery_count;
      logic             pd_en;
      logic [7:0]       los_cnt;
      logic [7:0][7:0]  global_clock_mode_regs;
      logic [11:0][7:0] sig;
      logic [7:0]       rdata;
      logic             rx_rst;
      logic             tx_rst;
      logic [7:0]       fifo_data;
      logic             fifo_vld;
      logic             set_evt;
      logic             clr_evt;
   } tjil_top_st_t;

   // bits in one LOS interval: (count + 1) * 16
   function automatic logic [12:0] tjil_los_limit(input logic [7:0] cnt);
      return 13'({5'h00, cnt} + 13'h0001) << 4;
   endfunction

endpackage

// ---- logic/tjil_los_mon.sv ----
// Purpose: loss-of-signal detection and recovery on the receive marks
// Assumes: rx strobe and marks come from logic on core_clk_i
// Notes:   recovery is judged at the end of each interval
`timescale 1ns/100ps
`default_nettype none
module tjil_los_mon
   import tjil_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clr_i,
   input  wire logic       stb_i,
   input  wire logic       mark_i,
   input  wire logic [7:0] pcd_i,
   input  wire logic [7:0] pcr_i,
   input  wire logic       pd_en_i,
   output logic            los_o,
   output logic            rise_o,
   output logic            fall_o
);
   tjil_los_st_t s_reg;
   tjil_los_st_t s_next;

   always_comb begin
      logic [12:0] lim;
      logic [8:0]  need;
      lim  = tjil_los_limit(pcd_i);
      need = {1'b0, pcr_i} + 9'h001;
      s_next      = s_reg;
      s_next.rise = 1'b0;
      s_next.fall = 1'b0;
      if (clr_i) begin
         s_next = '0;
      end else if (stb_i && !s_reg.los) begin
         // R10: zero run to los
         s_next.zrun = mark_i ? 13'h0000 : 13'(s_reg.zrun + 13'h0001);
         if (!mark_i && s_next.zrun >= lim) begin
            s_next.los  = 1'b1;
            s_next.rise = 1'b1;
            s_next.win  = '0;
            s_next.ones = '0;
            s_next.zr15 = '0;
            s_next.z15  = 1'b0;
         end
      end else if (stb_i) begin
         s_next.win = 13'(s_reg.win + 13'h0001);
         if (mark_i) begin
            s_next.zr15 = '0;
            if (s_reg.ones != ONES_SAT) begin
               s_next.ones = 9'(s_reg.ones + 9'h001);
            end
         end else begin
            s_next.zr15 = 4'(s_reg.zr15 + 4'h1);
            // R12: watch 15-zero runs
            if (s_next.zr15 == PD_ZERO_RUN) begin
               s_next.z15 = 1'b1;
            end
         end
         if (s_next.win >= lim) begin
            // R11: enough ones clears
            // R12: density check blocks
            if (s_next.ones >= need && !(pd_en_i && s_next.z15)) begin
               s_next.los  = 1'b0;
               s_next.fall = 1'b1;
               s_next.zrun = '0;
            end
            s_next.win  = '0;
            s_next.ones = '0;
            s_next.zr15 = '0;
            s_next.z15  = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign los_o  = s_reg.los;
   assign rise_o = s_reg.rise;
   assign fall_o = s_reg.fall;
endmodule // tjil_los_mon
`default_nettype wire

// ---- logic/tjil_line_coder.sv ----
// Purpose: transmit line coder, NRZ / AMI / AMI with bit 7 stuffing / B8ZS
// Assumes: tx strobe and data come from logic on core_clk_i
// Notes:   eight-bit delay in every code so latency never changes
`timescale 1ns/100ps
`default_nettype none
module tjil_line_coder
   import tjil_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       clr_i,
   input  wire logic       stb_i,
   input  wire logic       data_i,
   input  wire tjil_pkg::tjil_code_t code_i,
   input  wire logic       dual_i,
   input  wire logic       precode_i,
   output logic            pos_o,
   output logic            neg_o
);
   tjil_cod_st_t s_reg;
   tjil_cod_st_t s_next;

   always_comb begin
      logic pulse;
      logic np;
      logic bip;
      logic sub;
      pulse  = s_reg.slot[7] != SYM_ZERO;
      np     = (s_reg.slot[7] == SYM_V) ? s_reg.pol : ~s_reg.pol;
      bip    = dual_i && code_i != CODE_NRZ;
      // single rail without precoding gets plain marks
      sub    = code_i == CODE_B8ZS && (dual_i || precode_i);
      s_next = s_reg;
      if (clr_i) begin
         s_next = '0;
      end else if (stb_i) begin
         // R14: alternate marks, violations keep polarity
         if (pulse && code_i != CODE_NRZ) begin
            s_next.pol = np;
         end
         s_next.lp   = bip ? (pulse && np) : pulse;
         s_next.ln   = bip && pulse && !np;
         s_next.slot = {s_reg.slot[6:0], data_i ? SYM_MARK : SYM_ZERO};
         s_next.cnt  = 3'(s_reg.cnt + 3'h1);
         // R14: bit 7 stuffing
         if (code_i == CODE_AMI_ZCS && s_reg.cnt == CH_LAST_BIT &&
             s_next.slot == '0) begin
            s_next.slot[1] = SYM_MARK;
         end
         // R14: B8ZS substitution
         if (sub && s_next.slot == '0) begin
            s_next.slot = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_V,
                           SYM_B, SYM_ZERO, SYM_V, SYM_B};
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pos_o = s_reg.lp;
   assign neg_o = s_reg.ln;
endmodule // tjil_line_coder
`default_nettype wire

// ---- logic/tjil_top.sv ----
// What this block does
// R1: host configures only after reset released
// R2: basic and operational set before activation
// R3: configuration order is only a recommendation
// R4: primary bit high for T1/J1, else E1
// R5: japan select picks J1 over T1
// R6: optional features enabled after line runs
// R7: unassigned reads return don't-care data
// R8: unassigned writes ignored, host writes none
// R9: control registers read/write except four groups
// R10: los after (count+1)*16 zeros
// R11: recovery needs (count+1) ones per interval
// R12: density option forbids 15-zero runs
// R13: extra flag adds alarm clear events
// R14: AMI, stuffing, B8ZS, precode, NRZ supported
// R15: host sets clock mode registers first
// R16: host soft-resets both paths afterwards
//
// Purpose: register file, mode selection, LOS and line coding
// Assumes: rx and tx bit strobes come from logic on core_clk_i
// Notes:   read data stand only in the cycle after the read strobe
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tjil_top
   import tjil_pkg::*;
(
   input  wire logic            core_clk_i,
   input  wire logic            reset_n_i,
   input  wire tjil_pkg::tjil_bus_t bus_i,
   output logic [7:0]           rdata_o,
   input  wire tjil_pkg::tjil_rx_t  rx_i,
   input  wire logic            tx_stb_i,
   input  wire logic            tx_data_i,
   output logic                 line_pos_o,
   output logic                 line_neg_o,
   output logic                 los_o,
   output logic                 e1_mode_o,
   output logic                 j1_mode_o,
   output logic                 alarm_set_evt_o,
   output logic                 alarm_clr_evt_o,
   output logic [63:0]          clk_mode_o,
   output logic [95:0]          tx_sig_o,
   output logic [7:0]           fifo_data_o,
   output logic                 fifo_vld_o,
   output logic                 rx_reset_o,
   output logic                 tx_reset_o
);
   tjil_top_st_t s_reg;
   tjil_top_st_t s_next;
   logic         los;
   logic         los_rise;
   logic         los_fall;
   logic         rx_mark;

   // ==========================================================
   // address classes
   function automatic logic is_clk_mode(input logic [7:0] a);
      return a[7:3] == A_CLK_MODE_HI;
   endfunction

   function automatic logic is_tx_sig(input logic [7:0] a);
      return a[7:4] == A_TX_SIG_HI && a[3:0] < TX_SIG_COUNT;
   endfunction

   // ==========================================================
   // receive marks: the pos rail always counts as a pulse, the neg rail only in dual rail mode
   assign rx_mark = rx_i.pos || (s_reg.dual && rx_i.neg);

   // ==========================================================
   // register file
   always_comb begin
      logic [7:0] a;
      logic [7:0] w;
      a = bus_i.addr;
      w = bus_i.wdata;
      s_next           = s_reg;
      s_next.rdata     = RST_BYTE;
      s_next.rx_rst    = 1'b0;
      s_next.tx_rst    = 1'b0;
      s_next.fifo_vld  = 1'b0;
      s_next.set_evt   = 1'b0;
      s_next.clr_evt   = 1'b0;

      // R8: unmapped writes fall through
      if (bus_i.wr) begin
         case (a)
            A_GLOBAL_CFG: begin
               s_next.extra_recovery_irq_en = w[0];
            end
            A_PRIMARY: begin
               s_next.primary_mode_select = w[0];
            end
            A_RX_CTRL: begin
               s_next.j1 = w[0];
            end
            A_LINE_CODE: begin
               s_next.code    = tjil_code_t'(w[B_CODE_LO +: 2]);
               s_next.dual    = w[B_DUAL_RAIL];
               s_next.precode = w[B_PRECODE];
            end
            A_LOS_DETECT: begin
               s_next.los_detect_count = w;
            end
            A_LOS_RECOVER: begin
               s_next.los_recovery_count = w;
            end
            A_LINE_IF2: begin
               s_next.pd_en = w[0];
            end
            A_COMMAND: begin
               s_next.rx_rst = w[B_CMD_RX_RESET];
               s_next.tx_rst = w[B_CMD_TX_RESET];
            end
            A_TX_FIFO: begin
               s_next.fifo_data = w;
               s_next.fifo_vld  = 1'b1;
            end
            default: begin
               if (is_clk_mode(a)) begin
                  s_next.global_clock_mode_regs[a[2:0]] = w;
               end else if (is_tx_sig(a)) begin
                  s_next.sig[a[3:0]] = w;
               end
            end
         endcase
      end

      // R9: write-only groups read zero
      // R7: unmapped reads give zero
      if (bus_i.rd) begin
         case (a)
            A_GLOBAL_CFG: begin
               s_next.rdata = {7'h00, s_reg.extra_recovery_irq_en};
            end
            A_PRIMARY: begin
               s_next.rdata = {7'h00, s_reg.primary_mode_select};
            end
            A_RX_CTRL: begin
               s_next.rdata = {7'h00, s_reg.j1};
            end
            A_LINE_CODE: begin
               s_next.rdata = {4'h0, s_reg.precode, s_reg.dual, s_reg.code};
            end
            A_LOS_DETECT: begin
               s_next.rdata = s_reg.los_detect_count;
            end
            A_LOS_RECOVER: begin
               s_next.rdata = s_reg.los_recovery_count;
            end
            A_LINE_IF2: begin
               s_next.rdata = {7'h00, s_reg.pd_en};
            end
            A_STATUS: begin
               s_next.rdata = {5'h00, j1_mode_o, e1_mode_o, los};
            end
            A_LOS_EVENTS: begin
               s_next.rdata = s_reg.los_cnt;
            end
            default: begin
               if (is_clk_mode(a)) begin
                  s_next.rdata = s_reg.global_clock_mode_regs[a[2:0]];
               end
            end
         endcase
      end

      // event count: a new loss wins over a decrement in the same cycle
      if (los_rise) begin
         if (s_reg.los_cnt != 8'hff) begin
            s_next.los_cnt = 8'(s_reg.los_cnt + 8'h01);
         end
      end else if (bus_i.wr && a == A_DECREMENT && s_reg.los_cnt != 8'h00) begin
         s_next.los_cnt = 8'(s_reg.los_cnt - 8'h01);
      end

      // R13: clear events only when enabled
      s_next.set_evt = los_rise;
      s_next.clr_evt = los_fall && s_reg.extra_recovery_irq_en;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // loss of signal
   tjil_los_mon u_los (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .clr_i      (s_reg.rx_rst),
      .stb_i      (rx_i.stb),
      .mark_i     (rx_mark),
      .pcd_i      (s_reg.los_detect_count),
      .pcr_i      (s_reg.los_recovery_count),
      .pd_en_i    (s_reg.pd_en),
      .los_o      (los),
      .rise_o     (los_rise),
      .fall_o     (los_fall)
   );

   // ==========================================================
   // transmit coding
   tjil_line_coder u_coder (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .clr_i      (s_reg.tx_rst),
      .stb_i      (tx_stb_i),
      .data_i     (tx_data_i),
      .code_i     (s_reg.code),
      .dual_i     (s_reg.dual),
      .precode_i  (s_reg.precode),
      .pos_o      (line_pos_o),
      .neg_o      (line_neg_o)
   );

   // ==========================================================
   // outputs
   // R4: cleared primary bit means E1
   assign e1_mode_o       = !s_reg.primary_mode_select;
   // R5: J1 only inside T1/J1 mode
   assign j1_mode_o       = s_reg.primary_mode_select && s_reg.j1;
   assign rdata_o         = s_reg.rdata;
   assign los_o           = los;
   assign alarm_set_evt_o = s_reg.set_evt;
   assign alarm_clr_evt_o = s_reg.clr_evt;
   assign clk_mode_o      = s_reg.global_clock_mode_regs;
   assign tx_sig_o        = s_reg.sig;
   assign fifo_data_o     = s_reg.fifo_data;
   assign fifo_vld_o      = s_reg.fifo_vld;
   assign rx_reset_o      = s_reg.rx_rst;
   assign tx_reset_o      = s_reg.tx_rst;
endmodule // tjil_top
`default_nettype wire

// ---- verification/tjil_top_props.sv ----
// Purpose: port-level properties of tjil_top
// Assumes: one clock core_clk_i, reset_n_i asynchronous and active low
// Notes:   shadow bits follow mode writes so mode outputs can be judged
`timescale 1ns/100ps
`default_nettype none
module tjil_top_props
   import tjil_pkg::*;
(
   input wire logic                core_clk_i,
   input wire logic                reset_n_i,
   input wire tjil_pkg::tjil_bus_t bus_i,
   input wire logic [7:0]          rdata_o,
   input wire tjil_pkg::tjil_rx_t  rx_i,
   input wire logic                tx_stb_i,
   input wire logic                tx_data_i,
   input wire logic                line_pos_o,
   input wire logic                line_neg_o,
   input wire logic                los_o,
   input wire logic                e1_mode_o,
   input wire logic                j1_mode_o,
   input wire logic                alarm_set_evt_o,
   input wire logic                alarm_clr_evt_o,
   input wire logic [63:0]         clk_mode_o,
   input wire logic [95:0]         tx_sig_o,
   input wire logic [7:0]          fifo_data_o,
   input wire logic                fifo_vld_o,
   input wire logic                rx_reset_o,
   input wire logic                tx_reset_o
);
   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic       sci_q;
   logic       primary_mode_select_q;
   logic       j1_q;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // ========
   // shadow of the mode bits
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         addr_q  <= 8'h00;
         wdata_q <= 8'h00;
         sci_q   <= 1'b0;
         primary_mode_select_q  <= 1'b0;
         j1_q    <= 1'b0;
      end else begin
         addr_q  <= bus_i.addr;
         wdata_q <= bus_i.wdata;
         if (bus_i.wr && bus_i.addr == A_GLOBAL_CFG) sci_q <= bus_i.wdata[0];
         if (bus_i.wr && bus_i.addr == A_PRIMARY) primary_mode_select_q <= bus_i.wdata[0];
         if (bus_i.wr && bus_i.addr == A_RX_CTRL) j1_q <= bus_i.wdata[0];
      end
   end

   // ========
   // properties
   property p_rd_idle;
      !$past(bus_i.rd) |-> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_wo;
      bus_i.rd && ((bus_i.addr[7:3] == 5'h01 && bus_i.addr[2:0] != 3'h0)
         || bus_i.addr > 8'h17) |=> rdata_o == 8'h00;
   endproperty
   a_wo: assert property (p_wo) else $error("write-only or free offset read back");
   property p_set;
      alarm_set_evt_o == ($past(los_o) && !$past(los_o, 2));
   endproperty
   a_set: assert property (p_set) else $error("set event not tied to los rise");
   property p_clr;
      alarm_clr_evt_o == ($past(los_o, 2) && !$past(los_o) && $past(sci_q)
         && !$past(rx_reset_o, 2));
   endproperty
   a_clr: assert property (p_clr) else $error("clear event wrong");
   property p_e1;
      $stable(primary_mode_select_q) |-> e1_mode_o == !primary_mode_select_q;
   endproperty
   a_e1: assert property (p_e1) else $error("e1 mode wrong");
   property p_j1;
      $stable(primary_mode_select_q) && $stable(j1_q) |-> j1_mode_o == (primary_mode_select_q && j1_q);
   endproperty
   a_j1: assert property (p_j1) else $error("j1 mode wrong");
   property p_fifo;
      bus_i.wr && bus_i.addr == A_TX_FIFO |=> fifo_vld_o && fifo_data_o == wdata_q;
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo byte not passed");
   property p_cmd;
      bus_i.wr && bus_i.addr == A_COMMAND |=> {tx_reset_o, rx_reset_o} == wdata_q[1:0];
   endproperty
   a_cmd: assert property (p_cmd) else $error("command pulses wrong");
   property p_clk;
      bus_i.wr && bus_i.addr[7:3] == A_CLK_MODE_HI |=> clk_mode_o[8 * addr_q[2:0] +: 8] == wdata_q;
   endproperty
   a_clk: assert property (p_clk) else $error("clock mode byte wrong");
   property p_sig;
      bus_i.wr && bus_i.addr[7:4] == A_TX_SIG_HI && bus_i.addr[3:0] < TX_SIG_COUNT
         |=> tx_sig_o[8 * addr_q[3:0] +: 8] == wdata_q;
   endproperty
   a_sig: assert property (p_sig) else $error("signaling byte wrong");
   property p_hold;
      !$past(tx_stb_i) && !$past(tx_reset_o) && !tx_reset_o
         |-> $stable(line_pos_o) && $stable(line_neg_o);
   endproperty
   a_hold: assert property (p_hold) else $error("line moved without strobe");
   property p_rail;
      !(line_pos_o && line_neg_o);
   endproperty
   a_rail: assert property (p_rail) else $error("both rails marked");
endmodule // tjil_top_props

bind tjil_top tjil_top_props i_props (.core_clk_i, .reset_n_i, .bus_i, .rdata_o, .rx_i,
   .tx_stb_i, .tx_data_i, .line_pos_o, .line_neg_o, .los_o, .e1_mode_o, .j1_mode_o,
   .alarm_set_evt_o, .alarm_clr_evt_o, .clk_mode_o, .tx_sig_o, .fifo_data_o, .fifo_vld_o,
   .rx_reset_o, .tx_reset_o);
`default_nettype wire

// ---- verification/tjil_line_src.sv ----
// Purpose: remote line model feeding receive marks
// Assumes: strobes on core_clk_i, single rail marks on pos
// Notes:   between strobes the marks toggle so stale levels never look valid
`timescale 1ns/100ps
`default_nettype none
module tjil_line_src
   import tjil_pkg::*;
(
   input  wire logic          core_clk_i,
   input  wire logic          reset_n_i,
   input  wire logic          go_i,
   input  wire logic [8:0]    total_i,
   input  wire logic [8:0]    ones_i,
   input  wire logic          spread_i,
   input  wire logic          gap_i,
   output var tjil_pkg::tjil_rx_t rx_o,
   output logic               busy_o
);
   logic [8:0] cnt;
   logic       ph;
   // ========
   // burst of total_i bits, ones leading or one mark every eight bits
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt    <= 9'h000;
         ph     <= 1'b0;
         busy_o <= 1'b0;
         rx_o   <= '0;
      end else if (busy_o && !(gap_i && !ph)) begin
         rx_o.stb <= 1'b1;
         rx_o.pos <= spread_i ? (cnt[2:0] == 3'h0) : (cnt < ones_i);
         rx_o.neg <= 1'b0;
         cnt      <= cnt + 9'h001;
         ph       <= 1'b0;
         busy_o   <= (cnt != total_i - 9'h001);
      end else begin
         rx_o.stb <= 1'b0;
         rx_o.pos <= ~rx_o.pos;
         rx_o.neg <= ~rx_o.neg;
         ph       <= 1'b1;
         if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            cnt    <= 9'h000;
         end
      end
   end
endmodule // tjil_line_src
`default_nettype wire

// ---- verification/tjil_tb.sv ----
// Purpose: register, LOS and line coder tests of tjil_top
// Assumes: 10 MHz core clock, bus changed by nba at the rising edge
// Notes:   detect count 0x0a gives 176-bit windows
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
   import tjil_pkg::*;
   logic core_clk_i, reset_n_i, tx_stb_i, tx_data_i, line_pos_o, line_neg_o, los_o;
   logic e1_mode_o, j1_mode_o, alarm_set_evt_o, alarm_clr_evt_o, fifo_vld_o;
   logic rx_reset_o, tx_reset_o, go, spread, gap, busy;
   tjil_bus_t   bus_i;
   tjil_rx_t    rx_i;
   logic [8:0]  total, ones;
   logic [7:0]  rdata_o, fifo_data_o, a, v;
   logic [63:0] clk_mode_o;
   logic [95:0] tx_sig_o;
   logic [7:0]  rwv [7] = '{8'h01, 8'h01, 8'h01, 8'h0f, 8'h0a, 8'h15, 8'h01};
   logic [7:0]  wo [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h18, 8'h20, 8'h2b, 8'h2c, 8'hb0};
   int          fails, total_checks, cycles;

   tjil_top i_dut (.core_clk_i, .reset_n_i, .bus_i, .rdata_o, .rx_i, .tx_stb_i, .tx_data_i,
      .line_pos_o, .line_neg_o, .los_o, .e1_mode_o, .j1_mode_o, .alarm_set_evt_o,
      .alarm_clr_evt_o, .clk_mode_o, .tx_sig_o, .fifo_data_o, .fifo_vld_o, .rx_reset_o,
      .tx_reset_o);
   tjil_line_src i_line (.core_clk_i, .reset_n_i, .go_i(go), .total_i(total), .ones_i(ones),
      .spread_i(spread), .gap_i(gap), .rx_o(rx_i), .busy_o(busy));

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 10000) begin
         fails++;
         close_out();
      end
   end

   // ========
   // bus and line tasks
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge core_clk_i);
      bus_i <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      bus_i.wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      @(posedge core_clk_i);
      bus_i <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      bus_i.rd <= 1'b0;
      @(posedge core_clk_i);
      `CHK("rdata", e, rdata_o)
   endtask
   task automatic send(input logic [8:0] n, input logic [8:0] k, input logic s, input logic g);
      @(posedge core_clk_i);
      total <= n;
      ones <= k;
      spread <= s;
      gap <= g;
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
      @(posedge core_clk_i);
      for (int i = 0; i < 1000 && busy; i++) @(posedge core_clk_i);
      repeat (3) @(posedge core_clk_i);
   endtask
   // eight-strobe coder delay: bit j shows at loop step j + 10
   task automatic tx_row(input logic [7:0] code, input logic [15:0] dat, input logic [31:0] ex);
      wr(A_LINE_CODE, code);
      wr(A_COMMAND, 8'h02);
      @(posedge core_clk_i);
      for (int k = 0; k < 26; k++) begin
         @(posedge core_clk_i);
         if (k >= 10) `CHK("line", ex[31 - 2 * (k - 10) -: 2], {line_pos_o, line_neg_o})
         tx_stb_i <= (k < 24);
         tx_data_i <= (k < 16) ? dat[15 - k] : 1'b0;
      end
   endtask

   // ========
   // main sequence
   initial begin
      reset_n_i = 1'b0;
      bus_i = '0;
      tx_stb_i = 1'b0;
      tx_data_i = 1'b0;
      go = 1'b0;
      total = 9'h000;
      ones = 9'h000;
      spread = 1'b0;
      gap = 1'b0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      rdc(A_STATUS, 8'h02);
      rdc(A_PRIMARY, 8'h00);
      for (int i = 0; i < 15; i++) begin
         a = (i < 7) ? 8'(i) : 8'(i + 9);
         v = (i < 7) ? rwv[i] : 8'(i) ^ 8'h5a;
         wr(a, v);
         rdc(a, v);
      end
      rdc(A_STATUS, 8'h04);
      wr(A_RX_CTRL, 8'h00);
      rdc(A_STATUS, 8'h00);
      wr(A_PRIMARY, 8'h00);
      rdc(A_STATUS, 8'h02);
      wr(A_PRIMARY, 8'h01);
      for (int i = 0; i < 12; i++) wr(8'(i + 32), 8'(i + 192));
      @(posedge core_clk_i);
      for (int i = 0; i < 12; i++) `CHK("tx_sig", 8'(i + 192), tx_sig_o[8 * i +: 8])
      wr(A_TX_FIFO, 8'h3c);
      wr(8'h0c, 8'h00);
      foreach (wo[i]) rdc(wo[i], 8'h00);
      wr(A_LINE_IF2, 8'h00);
      wr(A_LINE_CODE, 8'h00);
      send(9'd175, 9'd0, 1'b0, 1'b1);
      rdc(A_STATUS, 8'h00);
      send(9'd1, 9'd0, 1'b0, 1'b1);
      rdc(A_STATUS, 8'h01);
      rdc(A_LOS_EVENTS, 8'h01);
      send(9'd176, 9'd21, 1'b0, 1'b0);
      rdc(A_STATUS, 8'h01);
      wr(A_LINE_IF2, 8'h01);
      send(9'd176, 9'd22, 1'b0, 1'b0);
      rdc(A_STATUS, 8'h01);
      send(9'd176, 9'd0, 1'b1, 1'b0);
      rdc(A_STATUS, 8'h00);
      wr(A_DECREMENT, 8'h01);
      rdc(A_LOS_EVENTS, 8'h00);
      wr(A_COMMAND, 8'h03);
      tx_row(8'h05, 16'hb080, 32'h8600_4000);
      tx_row(8'h06, 16'h0000, 32'h0008_0004);
      tx_row(8'h07, 16'h0100, 32'h4002_0246);
      tx_row(8'h0b, 16'h0100, 32'h8002_028a);
      tx_row(8'h04, 16'hb080, 32'h8a00_8000);
      tx_row(8'h01, 16'hb080, 32'h8a00_8000);
      close_out();
   end
endmodule // testbench
`undef CHK
`default_nettype wire
